/* core/pmdt_regs.vh */
`ifndef PMDT_REGS_VH
`define PMDT_REGS_VH
// Register byte addresses
`define PMDT_SYS_CTRL_FIRST_ADDR  12'h000
`define PMDT_SYS_CTRL_SECOND_ADDR 12'h004
`define PMDT_TIMER_A_MODE_ADDR    12'h008
`define PMDT_IRQ_ENABLE_ADDR      12'h00c
`define PMDT_MODE_STATUS_ADDR     12'h010
`define PMDT_SLEEP_CMD_ADDR       12'h014
// sys_ctrl_first fields
`define PMDT_STANDBY_BIT 7
`define PMDT_STS_HI     6
`define PMDT_STS_LO     4
`define PMDT_LOW_SPEED_BIT 3
`define PMDT_MA_HI      1
`define PMDT_MA_LO      0
// sys_ctrl_second fields
`define PMDT_MED_SPEED_BIT 3
`define PMDT_DIRECT_BIT    2
`define PMDT_SA_HI      1
`define PMDT_SA_LO      0
// timer_a_mode_reg field
`define PMDT_TMR_A_BIT3 3
// irq enable fields
`define PMDT_IEN_EXT0   0
`define PMDT_IEN_EXT1   1
`define PMDT_IEN_TMR_A  2
`define PMDT_IEN_DT     3
`define PMDT_IEN_OTHER  4
// Reset values
`define PMDT_SYS_CTRL_FIRST_RST  8'h00
`define PMDT_SYS_CTRL_SECOND_RST 8'h00
`define PMDT_TMR_A_RST           8'h00
`define PMDT_IEN_RST    8'h00
// Settling wait base, in states
`define PMDT_SETTLE_BASE 8192
// Modes
`define PMDT_M_ACT_HS  3'h0
`define PMDT_M_ACT_MS  3'h1
`define PMDT_M_SUBACT  3'h2
`define PMDT_M_SLP_HS  3'h3
`define PMDT_M_SLP_MS  3'h4
`define PMDT_M_STANDBY 3'h5
`define PMDT_M_WATCH   3'h6
`define PMDT_M_SUBSLP  3'h7
`endif

/* core/pmdt_sync.v */
`timescale 1ns/10ps
// Reset value of each stage matches the idle level of its pin
module pmdt_sync #(
  parameter         W    = 4,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pmdt_sync

/* core/pmdt_clkdiv.v */
`timescale 1ns/10ps
`include "pmdt_regs.vh"
// Produces the CPU clock enable for the current run mode
module pmdt_clkdiv (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire [2:0] mode,
  input  wire [1:0] medium_div,
  input  wire [1:0] subactive_div,
  input  wire       watch_tick,
  output reg        cpu_clk_en
);
  reg [5:0] cnt;
  reg [3:0] wcnt;
  reg       next_en;
  always @* begin
    next_en = 1'b0;
    case (mode)
      `PMDT_M_ACT_HS: next_en = 1'b1;
      `PMDT_M_ACT_MS: begin
        // Divide by 8,16,32,64 per medium divider bits
        case (medium_div)
          2'h0:    next_en = (cnt[2:0] == 3'h7);
          2'h1:    next_en = (cnt[3:0] == 4'hf);
          2'h2:    next_en = (cnt[4:0] == 5'h1f);
          default: next_en = (cnt == 6'h3f);
        endcase
      end
      `PMDT_M_SUBACT: begin
        // Watch clock divided by 2, 4 or 8
        if (watch_tick) begin
          case (subactive_div)
            2'h0:    next_en = (wcnt[2:0] == 3'h7);
            2'h1:    next_en = (wcnt[1:0] == 2'h3);
            default: next_en = wcnt[0];
          endcase
        end
      end
      default: next_en = 1'b0;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 6'h00;
      wcnt       <= 4'h0;
      cpu_clk_en <= 1'b0;
    end else begin
      cnt        <= cnt + 6'h01;
      if (watch_tick)
        wcnt <= wcnt + 4'h1;
      cpu_clk_en <= next_en;
    end
  end
endmodule // pmdt_clkdiv

/* core/pmdt_ctrl.v */
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "pmdt_regs.vh"
// Functional notes
// (R1) Medium-speed select set, low-speed clear: wakes from standby/watch/medium sleep go medium active.
// (R2) Wake suppressed when interrupt mask is 1 or source disabled.
// (R3) Medium active left only by SLEEP or reset pin low.
// (R4) SLEEP: standby set, low-speed clear, timer bit3 clear gives standby.
// (R5) SLEEP: standby set and timer bit3 set gives watch.
// (R6) Standby and low-speed clear: SLEEP gives high or medium sleep by medium select.
// (R7) Reset pin low resets CPU and ends medium active at once.
// (R8) Medium active CPU clock divided per the two medium divider bits.
// (R9) Direct-transfer bit set: SLEEP moves between run modes, then direct-transfer interrupt.
// (R10) Direct-transfer interrupt disabled: enter sleep or watch instead.
// (R11) Direct transfer with mask set leaves sleep/watch no interrupt can clear.
// (R12) High active to medium active via sleep when medium and direct bits set.
// (R13) Medium active to high active via sleep when medium clear, direct set.
// (R14) High active to subactive via watch with standby, low-speed, direct, bit3 set.
// (R15) Subactive to high active via watch after settling wait.
// (R16) Medium active to subactive via watch with standby, low-speed, direct, bit3 set.
// (R17) Subactive to medium active via watch after settling wait, medium select set.
// (R18) Watch wake goes high, medium or subactive per low- and medium-speed bits.
// (R19) Subactive CPU clock is watch clock divided by 2, 4 or 8.
// (R20) After reset the controller is in high active with control bits at reset.
module pmdt_ctrl #(
  parameter SETTLE_BASE = `PMDT_SETTLE_BASE
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        reset_pin_n,
  input  wire        ext_irq_zero,
  input  wire        ext_irq_one,
  input  wire        timer_a_irq,
  input  wire        other_irq,
  input  wire        watch_clk,
  input  wire        int_mask,
  input  wire        sleep_exec,
  output reg         cpu_reset,
  output reg  [2:0]  power_mode,
  output reg         dt_irq,
  output reg         wake_irq,
  output wire        cpu_clk_en
);
  reg  [7:0]  sys_ctrl_first;
  reg  [7:0]  sys_ctrl_second;
  reg  [7:0]  timer_a_mode_reg;
  reg  [7:0]  irq_enable;
  reg         dp_write;
  reg  [11:0] dp_addr;
  reg         pend_dt;
  reg  [2:0]  pend_target;
  reg         settling;
  reg  [2:0]  settle_target;
  reg         settle_irq_dt;
  reg  [20:0] settle_cnt;
  reg         wclk_d;
  reg         sleep_cmd;
  reg  [31:0] next_rdata;
  wire [4:0]  sync_out;
  wire        s_rst_n;
  wire        s_ext0;
  wire        s_ext1;
  wire        s_wclk;
  wire        s_tmr_a;
  wire        standby_select;
  wire        low_speed_select;
  wire        medium_speed_select;
  wire        direct_transfer_on;
  wire        timer_a_mode_bit3;
  wire        sleep_any;
  wire        dt_allowed;
  wire        wake_ok;
  wire        is_run;
  wire [20:0] settle_len;

  pmdt_sync #(
    .W    (5),
    .INIT (5'h01)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({timer_a_irq, watch_clk, ext_irq_one, ext_irq_zero, reset_pin_n}),
    .dout    (sync_out)
  );
  assign s_rst_n = sync_out[0];
  assign s_ext0  = sync_out[1];
  assign s_ext1  = sync_out[2];
  assign s_wclk  = sync_out[3];
  assign s_tmr_a = sync_out[4];

  pmdt_clkdiv u_div (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .mode          (power_mode),
    .medium_div    (sys_ctrl_first[`PMDT_MA_HI:`PMDT_MA_LO]),     // R8
    .subactive_div (sys_ctrl_second[`PMDT_SA_HI:`PMDT_SA_LO]),    // R19
    .watch_tick    (s_wclk & ~wclk_d),
    .cpu_clk_en    (cpu_clk_en)
  );

  assign standby_select      = sys_ctrl_first[`PMDT_STANDBY_BIT];
  assign low_speed_select    = sys_ctrl_first[`PMDT_LOW_SPEED_BIT];
  assign medium_speed_select = sys_ctrl_second[`PMDT_MED_SPEED_BIT];
  assign direct_transfer_on  = sys_ctrl_second[`PMDT_DIRECT_BIT];
  assign timer_a_mode_bit3   = timer_a_mode_reg[`PMDT_TMR_A_BIT3];
  assign sleep_any  = sleep_exec | sleep_cmd;
  assign is_run     = (power_mode == `PMDT_M_ACT_HS) | (power_mode == `PMDT_M_ACT_MS) |
                      (power_mode == `PMDT_M_SUBACT);
  // Direct transfer completes only if unmasked and its interrupt enabled
  assign dt_allowed = direct_transfer_on & ~int_mask & irq_enable[`PMDT_IEN_DT]; // R10 R11
  assign settle_len = SETTLE_BASE[20:0] << sys_ctrl_first[`PMDT_STS_HI:`PMDT_STS_LO];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  // Wake source qualification per low-power mode
  reg wake_src;
  always @* begin
    wake_src = 1'b0;
    case (power_mode)
      `PMDT_M_STANDBY: wake_src = (s_ext0 & irq_enable[`PMDT_IEN_EXT0]) |
                                  (s_ext1 & irq_enable[`PMDT_IEN_EXT1]);              // R1
      `PMDT_M_WATCH:   wake_src = (s_ext0 & irq_enable[`PMDT_IEN_EXT0]) |
                                  (s_tmr_a & irq_enable[`PMDT_IEN_TMR_A]);            // R1
      `PMDT_M_SLP_HS,
      `PMDT_M_SLP_MS,
      `PMDT_M_SUBSLP:  wake_src = (s_ext0 & irq_enable[`PMDT_IEN_EXT0]) |
                                  (s_ext1 & irq_enable[`PMDT_IEN_EXT1]) |
                                  (s_tmr_a & irq_enable[`PMDT_IEN_TMR_A]) |
                                  (other_irq & irq_enable[`PMDT_IEN_OTHER]);          // R1
      default:         wake_src = 1'b0;
    endcase
  end
  assign wake_ok = wake_src & ~int_mask & ~settling; // R2 R11

  // AHB-Lite slave, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else if (hready) begin
      dp_write <= hsel & htrans[1] & hwrite;
      dp_addr  <= haddr;
    end
  end

  // Read data is picked in the address phase and held through the data phase;
  // a write landing in the same cycle to the same register is forwarded
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      `PMDT_SYS_CTRL_FIRST_ADDR:  next_rdata = {24'h000000, sys_ctrl_first};
      `PMDT_SYS_CTRL_SECOND_ADDR: next_rdata = {24'h000000, sys_ctrl_second};
      `PMDT_TIMER_A_MODE_ADDR:    next_rdata = {24'h000000, timer_a_mode_reg};
      `PMDT_IRQ_ENABLE_ADDR:      next_rdata = {24'h000000, irq_enable};
      `PMDT_MODE_STATUS_ADDR:     next_rdata = {28'h0000000, settling, power_mode};
      default:                    next_rdata = 32'h0000_0000;
    endcase
    if (dp_write && (dp_addr == haddr) &&
        ((haddr == `PMDT_SYS_CTRL_FIRST_ADDR) || (haddr == `PMDT_SYS_CTRL_SECOND_ADDR) ||
         (haddr == `PMDT_TIMER_A_MODE_ADDR) || (haddr == `PMDT_IRQ_ENABLE_ADDR)))
      next_rdata = {24'h000000, hwdata[7:0]};
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= next_rdata;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_ctrl_first   <= `PMDT_SYS_CTRL_FIRST_RST;   // R20
      sys_ctrl_second  <= `PMDT_SYS_CTRL_SECOND_RST;  // R20
      timer_a_mode_reg <= `PMDT_TMR_A_RST;            // R20
      irq_enable       <= `PMDT_IEN_RST;      // R20
      sleep_cmd        <= 1'b0;
    end else begin
      sleep_cmd <= 1'b0;
      if (dp_write) begin
        case (dp_addr)
          `PMDT_SYS_CTRL_FIRST_ADDR:  sys_ctrl_first   <= hwdata[7:0];
          `PMDT_SYS_CTRL_SECOND_ADDR: sys_ctrl_second  <= hwdata[7:0];
          `PMDT_TIMER_A_MODE_ADDR:    timer_a_mode_reg <= hwdata[7:0];
          `PMDT_IRQ_ENABLE_ADDR:      irq_enable       <= hwdata[7:0];
          `PMDT_SLEEP_CMD_ADDR:       sleep_cmd        <= hwdata[0];
          default:                    sleep_cmd        <= 1'b0;
        endcase
      end
    end
  end

  // Mode sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_mode    <= `PMDT_M_ACT_HS;        // R20
      cpu_reset     <= 1'b1;
      dt_irq        <= 1'b0;
      wake_irq      <= 1'b0;
      settling      <= 1'b0;
      settle_target <= `PMDT_M_ACT_HS;
      settle_irq_dt <= 1'b0;
      settle_cnt    <= 21'h000000;
      pend_dt       <= 1'b0;
      pend_target   <= `PMDT_M_ACT_HS;
      wclk_d        <= 1'b0;
    end else begin
      wclk_d   <= s_wclk;
      dt_irq   <= 1'b0;
      wake_irq <= 1'b0;
      cpu_reset <= ~s_rst_n;
      if (!s_rst_n) begin
        // Reset pin ends any mode at once
        power_mode <= `PMDT_M_ACT_HS; // R7 R3
        settling   <= 1'b0;
        pend_dt    <= 1'b0;
      end else if (settling) begin
        if (settle_cnt == 21'h000000) begin
          settling   <= 1'b0;
          power_mode <= settle_target;
          dt_irq     <= settle_irq_dt;  // R15 R17
          wake_irq   <= ~settle_irq_dt;
        end else begin
          settle_cnt <= settle_cnt - 21'h000001;
        end
      end else if (pend_dt) begin
        // Passing through sleep or watch completes the direct transfer
        pend_dt <= 1'b0;
        if (pend_target == `PMDT_M_ACT_HS || pend_target == `PMDT_M_ACT_MS) begin
          if (power_mode == `PMDT_M_WATCH) begin
            settling      <= 1'b1;                  // R15 R17
            settle_target <= pend_target;
            settle_irq_dt <= 1'b1;
            settle_cnt    <= settle_len;
          end else begin
            power_mode <= pend_target;              // R12 R13
            dt_irq     <= 1'b1;                     // R9
          end
        end else begin
          power_mode <= pend_target;                // R14 R16
          dt_irq     <= 1'b1;                       // R9
        end
      end else if (is_run && sleep_any) begin       // R3
        if (standby_select && timer_a_mode_bit3) begin
          power_mode <= `PMDT_M_WATCH;              // R5
          if (dt_allowed) begin
            pend_dt <= 1'b1;
            if (power_mode == `PMDT_M_SUBACT && !low_speed_select)
              pend_target <= medium_speed_select ? `PMDT_M_ACT_MS : `PMDT_M_ACT_HS; // R15 R17
            else if (power_mode != `PMDT_M_SUBACT && low_speed_select)
              pend_target <= `PMDT_M_SUBACT;        // R14 R16
            else
              pend_dt <= 1'b0;
          end
        end else if (standby_select && !low_speed_select) begin
          power_mode <= `PMDT_M_STANDBY;            // R4
        end else if (!standby_select && !low_speed_select && power_mode != `PMDT_M_SUBACT) begin
          power_mode <= medium_speed_select ? `PMDT_M_SLP_MS : `PMDT_M_SLP_HS; // R6
          if (dt_allowed && (power_mode == `PMDT_M_ACT_HS) == medium_speed_select) begin
            pend_dt     <= 1'b1;                    // R12 R13
            pend_target <= medium_speed_select ? `PMDT_M_ACT_MS : `PMDT_M_ACT_HS;
          end
        end else if (!standby_select && low_speed_select && timer_a_mode_bit3 &&
                     power_mode == `PMDT_M_SUBACT) begin
          power_mode <= `PMDT_M_SUBSLP;
        end
      end else if (wake_ok) begin
        case (power_mode)
          `PMDT_M_SLP_HS: begin
            power_mode <= `PMDT_M_ACT_HS;
            wake_irq   <= 1'b1;
          end
          `PMDT_M_SLP_MS: begin
            power_mode <= `PMDT_M_ACT_MS;           // R1
            wake_irq   <= 1'b1;
          end
          `PMDT_M_SUBSLP: begin
            power_mode <= `PMDT_M_SUBACT;
            wake_irq   <= 1'b1;
          end
          `PMDT_M_WATCH: begin
            if (low_speed_select) begin
              power_mode <= `PMDT_M_SUBACT;         // R18
              wake_irq   <= 1'b1;
            end else begin
              settling      <= 1'b1;                // R18 R1
              settle_target <= medium_speed_select ? `PMDT_M_ACT_MS : `PMDT_M_ACT_HS;
              settle_irq_dt <= 1'b0;
              settle_cnt    <= settle_len;
            end
          end
          default: begin
            settling      <= 1'b1;                  // R1
            settle_target <= medium_speed_select ? `PMDT_M_ACT_MS : `PMDT_M_ACT_HS;
            settle_irq_dt <= 1'b0;
            settle_cnt    <= settle_len;
          end
        endcase
      end
    end
  end
endmodule // pmdt_ctrl

/* verif/pmdt_ctrl_props.sv */
`timescale 1ns/10ps
module pmdt_ctrl_chk (
  input wire       hclk,
  input wire       hresetn,
  input wire       reset_pin_n,
  input wire       int_mask,
  input wire       sleep_exec,
  input wire       cpu_reset,
  input wire [2:0] power_mode,
  input wire       dt_irq,
  input wire       wake_irq,
  input wire       cpu_clk_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pin_low;
    !reset_pin_n [*3];
  endsequence
  sequence s_masked;
    int_mask ##1 int_mask;
  endsequence
  AST_PIN_RESET: assert property (s_pin_low |-> ##[0:3] (cpu_reset && power_mode == 3'h0))
    else $error("reset pin low did not reset the cpu");
  AST_MASK_NO_WAKE: assert property (s_masked |-> !wake_irq)
    else $error("wake while interrupts masked");
  AST_DT_ONE: assert property (dt_irq |=> !dt_irq)
    else $error("direct transfer pulse too long");
  AST_DT_RUN: assert property (dt_irq |-> power_mode inside {3'h0, 3'h1, 3'h2})
    else $error("direct transfer ended outside a run mode");
  AST_DT_MS: assert property (dt_irq && power_mode == 3'h1 |-> $past(power_mode) inside {3'h4, 3'h6})
    else $error("medium active reached without sleep or watch");
  AST_DT_HS: assert property (dt_irq && power_mode == 3'h0 |-> $past(power_mode) inside {3'h3, 3'h6})
    else $error("high active reached without sleep or watch");
  AST_DT_SUB: assert property (dt_irq && power_mode == 3'h2 |-> $past(power_mode) == 3'h6)
    else $error("subactive reached without watch");
  AST_LEAVE_MS: assert property ($past(power_mode) == 3'h1 && power_mode != 3'h1 |->
    (($past(sleep_exec) || $past(sleep_exec, 2) || cpu_reset) or ##1 cpu_reset))
    else $error("medium active left without sleep or reset");
  AST_MS_CLK: assert property (power_mode == 3'h1 && $past(power_mode) == 3'h1 && cpu_clk_en
    |=> (!cpu_clk_en || power_mode != 3'h1) [*7])
    else $error("medium clock enable faster than one in eight");
endmodule // pmdt_ctrl_chk
bind pmdt_ctrl pmdt_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .reset_pin_n(reset_pin_n),
  .int_mask(int_mask), .sleep_exec(sleep_exec), .cpu_reset(cpu_reset),
  .power_mode(power_mode), .dt_irq(dt_irq), .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en));

/* verif/pmdt_cpu_model.sv */
`timescale 1ns/10ps
// CPU core, interrupt sources and reset pin; the bench sets the levels
module pmdt_cpu_model (
  input  wire hclk,
  output reg  reset_pin_n,
  output reg  ext_irq_zero,
  output reg  ext_irq_one,
  output reg  timer_a_irq,
  output reg  other_irq,
  output reg  watch_clk,
  output reg  int_mask,
  output reg  sleep_exec
);
  initial begin
    {ext_irq_zero, ext_irq_one, timer_a_irq, other_irq, int_mask, sleep_exec} = 6'h00;
    reset_pin_n = 1'b1;
    watch_clk = 1'b0;
    #3;
    forever #40 watch_clk = ~watch_clk;
  end
  // One-cycle pulse per executed SLEEP
  task slp;
    @(posedge hclk) sleep_exec <= 1'b1;
    @(posedge hclk) sleep_exec <= 1'b0;
  endtask
endmodule // pmdt_cpu_model

/* verif/pmdt_ctrl_bench.sv */
`timescale 1ns/10ps
module pmdt_ctrl_bench;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel, hwrite;
  reg  [11:0] haddr;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata, q;
  wire [31:0] hrdata;
  wire [2:0]  power_mode;
  wire        hreadyout, hresp, cpu_reset, dt_irq, wake_irq, cpu_clk_en;
  wire        reset_pin_n, ext_irq_zero, ext_irq_one, timer_a_irq, other_irq;
  wire        watch_clk, int_mask, sleep_exec;
  integer     mismatches = 0, n_compared = 0, n_dt = 0, n_wk = 0, j, c;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (dt_irq === 1'b1) n_dt <= n_dt + 1;
    if (wake_irq === 1'b1) n_wk <= n_wk + 1;
  end
  pmdt_cpu_model cpu (.hclk(hclk), .reset_pin_n(reset_pin_n), .ext_irq_zero(ext_irq_zero),
    .ext_irq_one(ext_irq_one), .timer_a_irq(timer_a_irq), .other_irq(other_irq),
    .watch_clk(watch_clk), .int_mask(int_mask), .sleep_exec(sleep_exec));
  pmdt_ctrl #(.SETTLE_BASE(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reset_pin_n(reset_pin_n), .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
    .timer_a_irq(timer_a_irq), .other_irq(other_irq), .watch_clk(watch_clk),
    .int_mask(int_mask), .sleep_exec(sleep_exec), .cpu_reset(cpu_reset),
    .power_mode(power_mode), .dt_irq(dt_irq), .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en));
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rdy;
    integer k;
    for (k = 0; k < 20 && hreadyout !== 1'b1; k = k + 1) @(posedge hclk);
    if (k == 20) begin
      mismatches = mismatches + 1;
      summarize;
    end
  endtask
  // Address phase, then data phase; each ends at an edge with hready high
  task bus(input [11:0] a, input w, input [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2; hsize <= 3'h2;
    @(posedge hclk);
    rdy;
    htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    rdy;
    q = hrdata;
  endtask
  task wm(input [2:0] m);
    integer k;
    for (k = 0; k < 400 && power_mode !== m; k = k + 1) @(posedge hclk);
    if (k == 400) begin
      mismatches = mismatches + 1;
      summarize;
    end
    cmp(power_mode, m);
  endtask
  task hold(input integer n, input [2:0] m);
    repeat (n) @(posedge hclk);
    cmp(power_mode, m);
  endtask
  task go(input [7:0] s1, input [7:0] s2, input [7:0] tm, input [2:0] m);
    bus(12'h000, 1'b1, s1); bus(12'h004, 1'b1, s2); bus(12'h008, 1'b1, tm);
    cpu.slp;
    wm(m);
  endtask
  // Periodic enable: a window of whole periods holds an exact count
  task ck(input [31:0] e);
    repeat (64) @(posedge hclk);
    c = 0;
    repeat (512) begin
      @(posedge hclk);
      if (cpu_clk_en === 1'b1) c = c + 1;
    end
    cmp(c, e);
  endtask
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = 51'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cmp(power_mode, 3'h0);
    for (j = 0; j <= 16; j = j + 4) begin
      bus(j[11:0], 1'b0, 32'h0); cmp(q, 32'h0);
    end
    bus(12'h100, 1'b1, 32'hff); bus(12'h100, 1'b0, 32'h0); cmp(q, 32'h0);
    cmp({hreadyout, hresp}, 32'h2);
    bus(12'h00c, 1'b1, 32'h1f);
    go(8'h00, 8'h08, 8'h00, 3'h4);
    cpu.other_irq <= 1'b1; wm(3'h1); cpu.other_irq <= 1'b0;
    for (j = 0; j < 4; j = j + 1) begin
      bus(12'h000, 1'b1, j); ck(64 >> j);
    end
    cmp(n_wk, 1);
    cpu.int_mask <= 1'b1; go(8'h80, 8'h08, 8'h00, 3'h5);
    cpu.ext_irq_one <= 1'b1; hold(50, 3'h5);
    cpu.int_mask <= 1'b0; wm(3'h1); cpu.ext_irq_one <= 1'b0;
    go(8'h80, 8'h08, 8'h08, 3'h6);
    cpu.timer_a_irq <= 1'b1; wm(3'h1); cpu.timer_a_irq <= 1'b0;
    go(8'h00, 8'h04, 8'h00, 3'h0);
    go(8'h88, 8'h04, 8'h08, 3'h2);
    for (j = 0; j < 3; j = j + 1) begin
      bus(12'h004, 1'b1, 4 + j); ck(8 << j);
    end
    go(8'h80, 8'h04, 8'h08, 3'h0);
    bus(12'h00c, 1'b1, 32'h17); cmp(n_dt, 3);
    go(8'h00, 8'h0c, 8'h00, 3'h4); hold(30, 3'h4);
    cpu.other_irq <= 1'b1; wm(3'h1); cpu.other_irq <= 1'b0;
    bus(12'h00c, 1'b1, 32'h1f);
    cpu.int_mask <= 1'b1; go(8'h00, 8'h04, 8'h00, 3'h3);
    cpu.ext_irq_zero <= 1'b1; cpu.other_irq <= 1'b1; hold(40, 3'h3);
    cpu.reset_pin_n <= 1'b0; wm(3'h0); cmp(cpu_reset, 1'b1);
    cpu.reset_pin_n <= 1'b1; {cpu.ext_irq_zero, cpu.other_irq, cpu.int_mask} <= 3'h0;
    hold(8, 3'h0); cmp(cpu_reset, 1'b0);
    bus(12'h00c, 1'b1, 32'h1f);
    bus(12'h014, 1'b1, 32'h1); wm(3'h3);
    cpu.other_irq <= 1'b1; wm(3'h0); cpu.other_irq <= 1'b0;
    go(8'h00, 8'h0c, 8'h00, 3'h1);
    go(8'h88, 8'h04, 8'h08, 3'h2);
    go(8'h80, 8'h0c, 8'h08, 3'h1);
    cpu.reset_pin_n <= 1'b0; wm(3'h0); cmp(cpu_reset, 1'b1);
    cmp(n_dt, 6); cmp(n_wk, 5);
    summarize;
  end
endmodule // pmdt_ctrl_bench
